// ---- hw/cwb_buffer.sv ----
// Chosen here: the address map and the AHB-Lite register port.
`include "cwb_consts.svh"

module cwb_buffer
  import cwb_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic [8:0] ch_byte_i,
  input wire logic ch_svc_i,
  output logic ch_ready_o,
  input wire logic ch_svc_out_i,
  input wire logic ch_inbound_tag_i,
  input wire logic ch_status_in_i,
  input wire logic ch_chain_data_i,
  output logic [8:0] ch_out_byte_o,
  input wire logic [31:0] st_fetch_word_i,
  input wire logic [15:0] st_count_i,
  input wire logic st_share_done_i,
  output logic st_share_req_o,
  output logic [31:0] st_store_word_o,
  output logic [3:0] st_mem_flag_o,
  output logic check_o
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] cwb_fold(input logic [15:0] c);
    // any high bit reads as twelve so the low bits matter only below sixteen
    cwb_fold = (|c[15:4]) ? `CWB_CNT_FORCE : c[3:0];
  endfunction : cwb_fold

  function automatic logic [3:0] cwb_flags(input logic [3:0] cnt, input logic [1:0] a,
                                           input logic bk);
    int c;
    int j;
    cwb_flags = 4'h0;
    c = (cnt > 4'h4) ? 4 : int'(cnt);
    for (j = 0; j < 4; j++) begin
      if (bk) begin
        cwb_flags[j] = (j <= int'(a)) && (j + c > int'(a));
      end else begin
        cwb_flags[j] = (j >= int'(a)) && (j < int'(a) + c);
      end
    end
  endfunction : cwb_flags

  function automatic logic [3:0] cwb_count(input logic [7:0] f);
    int j;
    cwb_count = 4'h0;
    for (j = 0; j < 8; j++) begin
      cwb_count = cwb_count + {3'h0, f[j]};
    end
  endfunction : cwb_count

  function automatic logic [4:0] cwb_par_cnt(input logic [3:0] n);
    cwb_par_cnt = {~^n, n};
  endfunction : cwb_par_cnt

  cwb_state_t s_q;
  cwb_state_t s_d;
  logic req;
  logic rd_grant;
  logic wr_grant;

  // ------------------------------------------------------------
  // share request
  // ------------------------------------------------------------
  always_comb begin
    req = 1'b0;
    if (s_q.cnt_rdy && (s_q.low_cnt != 4'h0)) begin
      if (s_q.rd_mode) begin
        req = (&s_q.full[`CWB_LOW_TOP:0]) | ch_status_in_i;
      end else begin
        req = ~|s_q.full[`CWB_IN_SLOT:`CWB_HIGH_BOT];
      end
    end
  end

  assign rd_grant = st_share_done_i & s_q.rd_mode;
  assign wr_grant = st_share_done_i & ~s_q.rd_mode;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [8:0] fx;
    logic [6:0] one;
    logic [5:0] two;
    logic blk;
    logic dpar;
    logic [3:0] force_m;
    logic do_arm;
    int i;
    fx = 9'h000;
    one = 7'h00;
    two = 6'h00;
    blk = 1'b0;
    dpar = 1'b0;
    force_m = 4'h0;
    do_arm = 1'b0;
    i = 0;
    s_d = s_q;

    // ------------------------------------------------------------
    // bus address phase
    // ------------------------------------------------------------
    // read data latched so the data phase answers at once
    s_d.ahb_act = hsel_i & hready_i & htrans_i[`CWB_HTRANS_NS];
    s_d.ahb_wr = hwrite_i;
    s_d.ahb_idx = haddr_i[31:2];
    s_d.hrdata = 32'h0000_0000;
    if (s_d.ahb_act && !hwrite_i) begin
      unique case (haddr_i[31:2])
        `CWB_OFF_CTRL: begin
          s_d.hrdata[`CWB_CTL_READ] = s_q.rd_mode;
          s_d.hrdata[`CWB_CTL_BACK] = s_q.back;
          s_d.hrdata[`CWB_CTL_HOLD] = s_q.hold;
          s_d.hrdata[`CWB_CTL_CRDY] = s_q.cnt_rdy;
        end
        `CWB_OFF_COUNT: s_d.hrdata[3:0] = s_q.low_cnt;
        `CWB_OFF_ADDR: s_d.hrdata[1:0] = s_q.low_addr;
        `CWB_OFF_STAT: begin
          s_d.hrdata[`CWB_ST_FULL +: 8] = s_q.full;
          s_d.hrdata[`CWB_ST_BYTES +: 5] = s_q.byte_cnt;
          s_d.hrdata[`CWB_ST_CHECK] = s_q.check;
          s_d.hrdata[`CWB_ST_REQ] = req;
          s_d.hrdata[`CWB_ST_BLK] = s_q.chain_blk;
          s_d.hrdata[`CWB_ST_FLAG +: 4] = s_q.mflag;
          s_d.hrdata[`CWB_ST_CNT +: 4] = s_q.low_cnt;
          s_d.hrdata[`CWB_ST_ADR +: 2] = s_q.low_addr;
        end
        default: s_d.hrdata = 32'h0000_0000;
      endcase
    end

    // ------------------------------------------------------------
    // bus data phase
    // ------------------------------------------------------------
    // unmapped writes are dropped
    if (s_q.ahb_act && s_q.ahb_wr) begin
      unique case (s_q.ahb_idx)
        `CWB_OFF_CTRL: begin
          s_d.rd_mode = hwdata_i[`CWB_CTL_READ];
          s_d.back = hwdata_i[`CWB_CTL_BACK];
          s_d.hold = hwdata_i[`CWB_CTL_HOLD];
          s_d.cnt_rdy = hwdata_i[`CWB_CTL_CRDY];
          do_arm = hwdata_i[`CWB_CTL_ARM];
        end
        `CWB_OFF_COUNT: s_d.low_cnt = cwb_fold(hwdata_i[15:0]);
        `CWB_OFF_ADDR: begin
          s_d.low_addr = hwdata_i[1:0];
          s_d.chain_blk = 1'b0;
        end
        `CWB_OFF_STAT: begin
          if (hwdata_i[`CWB_ST_CHECK]) begin
            s_d.check = 1'b0;
          end
        end
        default: s_d.chain_blk = s_d.chain_blk;
      endcase
    end
    // ------------------------------------------------------------
    // chain block
    // ------------------------------------------------------------
    // set after the address write so a chain pulse wins
    if (ch_chain_data_i) begin
      s_d.chain_blk = 1'b1;
    end

    // ------------------------------------------------------------
    // shift decisions
    // ------------------------------------------------------------
    // decided from followers, then masked by the low-slot block
    fx = {s_q.follow, 1'b1};
    blk = s_q.chain_blk | rd_grant;
    for (i = 0; i < 7; i++) begin
      one[i] = fx[i + 2] & ~fx[i + 1] & fx[i];
    end
    for (i = 0; i < 6; i++) begin
      two[i] = s_q.follow[i + 2] & ~s_q.follow[i + 1] & ~s_q.follow[i];
    end
    if (blk) begin
      one[`CWB_LOW_TOP] = 1'b0;
      two[`CWB_LOW_TOP] = 1'b0;
      two[`CWB_LOW_TOP - 1] = 1'b0;
    end
    // ------------------------------------------------------------
    // shift moves
    // ------------------------------------------------------------
    // every clock a pass; moves never collide since source set, dest empty
    for (i = 0; i < 7; i++) begin
      if (one[i]) begin
        s_d.data[i] = s_q.data[i + 1];
        s_d.full[i] = 1'b1;
        s_d.full[i + 1] = 1'b0;
      end
    end
    for (i = 0; i < 6; i++) begin
      if (two[i]) begin
        s_d.data[i] = s_q.data[i + 2];
        s_d.full[i] = 1'b1;
        s_d.full[i + 2] = 1'b0;
      end
    end

    // ------------------------------------------------------------
    // slot zero out
    // ------------------------------------------------------------
    // slot zero handed to the channel
    if (ch_svc_out_i && s_q.full[0]) begin
      s_d.full[0] = 1'b0;
      dpar = ~dpar;
    end

    // ------------------------------------------------------------
    // input register
    // ------------------------------------------------------------
    // read byte arrives in the input register
    if (s_q.rd_mode && ch_svc_i && !s_q.full[`CWB_IN_SLOT]) begin
      s_d.data[`CWB_IN_SLOT] = ch_byte_i;
      s_d.full[`CWB_IN_SLOT] = 1'b1;
      s_d.byte_cnt = s_q.byte_inc;
      dpar = ~dpar;
    end

    // ------------------------------------------------------------
    // store done
    // ------------------------------------------------------------
    // clear low slots; recount includes a byte entering this cycle
    if (rd_grant) begin
      s_d.full[`CWB_LOW_TOP:0] = 4'h0;
      dpar = dpar ^ (^s_q.full[`CWB_LOW_TOP:0]);
      s_d.byte_cnt = cwb_par_cnt(cwb_count(s_d.full));
    end

    // ------------------------------------------------------------
    // fetch load
    // ------------------------------------------------------------
    // fetched word enters the high slots, byte 0 nearest the output
    if (wr_grant) begin
      for (i = 0; i < 4; i++) begin
        if (s_q.mflag[i]) begin
          s_d.data[`CWB_HIGH_BOT + i] = {~^st_fetch_word_i[8 * i +: 8],
                                         st_fetch_word_i[8 * i +: 8]};
          s_d.full[`CWB_HIGH_BOT + i] = 1'b1;
        end
      end
      dpar = dpar ^ (^s_q.mflag);
    end

    // ------------------------------------------------------------
    // count and address update
    // ------------------------------------------------------------
    // after a grant the address sits on the word boundary
    if (st_share_done_i) begin
      s_d.low_cnt = cwb_fold(st_count_i);
      s_d.low_addr = s_q.back ? `CWB_ADR_BACK : `CWB_ADR_FWD;
    end

    // ------------------------------------------------------------
    // arm
    // ------------------------------------------------------------
    // pad unused leading bytes of a partial first read word
    if (do_arm && hwdata_i[`CWB_CTL_READ]) begin
      for (i = 0; i < 4; i++) begin
        if (hwdata_i[`CWB_CTL_BACK]) begin
          force_m[i] = (i < 3 - int'(s_d.low_addr));
        end else begin
          force_m[i] = (i < int'(s_d.low_addr));
        end
      end
      s_d.full[`CWB_LOW_TOP:0] = s_d.full[`CWB_LOW_TOP:0] | force_m;
      dpar = dpar ^ (^(force_m & ~s_q.full[`CWB_LOW_TOP:0]));
      s_d.byte_cnt = cwb_par_cnt(cwb_count(s_d.full));
    end

    // ------------------------------------------------------------
    // full-count check
    // ------------------------------------------------------------
    // parity of the full count changes only by bytes in and out
    if ((^s_d.full) != ((^s_q.full) ^ dpar)) begin
      s_d.check = 1'b1;
    end

    // ------------------------------------------------------------
    // followers, increment, flags
    // ------------------------------------------------------------
    // followers registered with full bits, so they match full every clock
    s_d.follow = s_d.full;
    s_d.byte_inc = cwb_par_cnt(s_d.byte_cnt[3:0] + 4'h1);
    s_d.mflag = cwb_flags(s_d.low_cnt, s_d.low_addr, s_d.rd_mode & s_d.back);

    // ------------------------------------------------------------
    // output register
    // ------------------------------------------------------------
    // tracks slot zero unless held or under the inbound tag
    if (!ch_inbound_tag_i && !s_q.hold) begin
      s_d.go = s_q.data[0];
    end

    // ------------------------------------------------------------
    // assembler
    // ------------------------------------------------------------
    // backward reads reverse the slot order
    for (i = 0; i < 4; i++) begin
      if (s_q.back) begin
        s_d.word[8 * i +: 8] = s_q.data[3 - i][7:0];
      end else begin
        s_d.word[8 * i +: 8] = s_q.data[i][7:0];
      end
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = s_q.hrdata;
  assign ch_ready_o = s_q.rd_mode & ~s_q.full[`CWB_IN_SLOT];
  assign ch_out_byte_o = s_q.go;
  assign st_share_req_o = req;
  assign st_store_word_o = s_q.word;
  assign st_mem_flag_o = s_q.mflag;
  assign check_o = s_q.check;

endmodule : cwb_buffer

// ---- hw/cwb_consts.svh ----
// Contract
// - output register follows slot zero unless hold or inbound tag; service-out empties slot zero
// - bytes advance one or two slots
// - shift every clock, several bytes move
// - followers copy full bits; they steer shifting
// - two-slot advance into two empty followers
// - one-slot advance between two set followers
// - source full bit clears when byte moves
// - read service byte sets input full
// - write load sets high full bits by flags
// - partial first read word forces low full bits
// - full-count parity check sets check latch
// - byte counter: four bits plus odd parity
// - increment latches hold count plus one
// - store clears low slots, recount remaining full
// - forward/backward byte order into storage word
// - write request when high four slots empty
// - read request when low four full
// - request needs count ready, nonzero count
// - status-in forces a read request
// - block shifting into low slots
// - low count latches, high bits force twelve
// - memory flags from count and address
`ifndef CWB_CONSTS_SVH
`define CWB_CONSTS_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define CWB_OFF_CTRL 30'h0000_0000
`define CWB_OFF_COUNT 30'h0000_0001
`define CWB_OFF_ADDR 30'h0000_0002
`define CWB_OFF_STAT 30'h0000_0003

// ------------------------------------------------------------
// control bits
// ------------------------------------------------------------
`define CWB_CTL_READ 0
`define CWB_CTL_BACK 1
`define CWB_CTL_HOLD 2
`define CWB_CTL_CRDY 3
`define CWB_CTL_ARM 4

// ------------------------------------------------------------
// status fields
// ------------------------------------------------------------
`define CWB_ST_FULL 0
`define CWB_ST_BYTES 8
`define CWB_ST_CHECK 13
`define CWB_ST_REQ 14
`define CWB_ST_BLK 15
`define CWB_ST_FLAG 16
`define CWB_ST_CNT 20
`define CWB_ST_ADR 24

// ------------------------------------------------------------
// slots, counts, bus codes
// ------------------------------------------------------------
`define CWB_IN_SLOT 7
`define CWB_LOW_TOP 3
`define CWB_HIGH_BOT 4
`define CWB_CNT_FORCE 4'hC
`define CWB_CNT_WORD 3'h4
`define CWB_ADR_BACK 2'h3
`define CWB_ADR_FWD 2'h0
`define CWB_HTRANS_NS 1

`endif

// ---- hw/cwb_pkg.sv ----
package cwb_pkg;
  typedef logic [8:0] cwb_byte_t;

  typedef struct packed {
    cwb_byte_t [7:0] data;
    logic [7:0] full;
    logic [7:0] follow;
    cwb_byte_t go;
    logic [4:0] byte_cnt;
    logic [4:0] byte_inc;
    logic check;
    logic [3:0] low_cnt;
    logic [1:0] low_addr;
    logic [3:0] mflag;
    logic [31:0] word;
    logic chain_blk;
    logic rd_mode;
    logic back;
    logic hold;
    logic cnt_rdy;
    logic ahb_act;
    logic ahb_wr;
    logic [29:0] ahb_idx;
    logic [31:0] hrdata;
  } cwb_state_t;
endpackage : cwb_pkg

// ---- sim/cwb_chk.sv ----
module cwb_chk (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic ch_svc_i,
  input wire logic ch_ready_o,
  input wire logic ch_inbound_tag_i,
  input wire logic ch_status_in_i,
  input wire logic [8:0] ch_out_byte_o,
  input wire logic st_share_done_i,
  input wire logic st_share_req_o,
  input wire logic [3:0] st_mem_flag_o,
  input wire logic check_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // port checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);
  AST_BUS_OK: assert property (hreadyout_o && !hresp_o)
    else $error("bus slave stalled or errored");
  AST_SVC_TAKE: assert property (ch_svc_i && ch_ready_o |=> !ch_ready_o)
    else $error("input slot still free after a taken byte");
  AST_OUT_HOLD: assert property (ch_inbound_tag_i |=> $stable(ch_out_byte_o))
    else $error("output byte moved under inbound tag");
  AST_GRANT_DROP: assert property (st_share_done_i && !ch_status_in_i |=> !st_share_req_o)
    else $error("request stands after its grant");
  AST_NO_CHECK: assert property (!check_o)
    else $error("full-bit parity check fired");
  AST_RST_QUIET: assert property ($rose(resetn_i) |-> !st_share_req_o && !ch_ready_o)
    else $error("request or ready right after reset");
  AST_FLAG_SHAPE: assert property (st_mem_flag_o inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8,
    4'h3, 4'h6, 4'hC, 4'h7, 4'hE, 4'hF})
    else $error("memory flags not a contiguous byte run");
  AST_REQ_FLAG: assert property (st_share_req_o |-> st_mem_flag_o != 4'h0)
    else $error("request with no byte flagged");
endmodule : cwb_chk

bind cwb_buffer cwb_chk i_chk (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .ch_svc_i(ch_svc_i), .ch_ready_o(ch_ready_o),
  .ch_inbound_tag_i(ch_inbound_tag_i), .ch_status_in_i(ch_status_in_i),
  .ch_out_byte_o(ch_out_byte_o), .st_share_done_i(st_share_done_i),
  .st_share_req_o(st_share_req_o), .st_mem_flag_o(st_mem_flag_o), .check_o(check_o));

// ---- sim/cwb_store_model.sv ----
module cwb_store_model (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic req_i,
  input wire logic [3:0] slow_i,
  input wire logic [31:0] word_i,
  input wire logic [15:0] cnt_i,
  output logic done_o,
  output logic [31:0] fetch_o,
  output logic [15:0] count_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q;
  // grant only while the request stands; slow_i stretches the wait
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || !req_i || done_o) begin
      wait_q <= 4'h0;
      done_o <= 1'b0;
    end else if (wait_q >= slow_i) begin
      done_o <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
  // inverse off-grant so stale data never passes
  assign fetch_o = done_o ? word_i : ~word_i;
  assign count_o = done_o ? cnt_i : ~cnt_i;
endmodule : cwb_store_model

// ---- sim/tb.sv ----
`include "cwb_consts.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
`define WAIT(c) for (w = 0; w < 300 && !(c); w++) begin @(posedge clk_sys_i); #1; end

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] AC = {`CWB_OFF_CTRL, 2'h0};
  localparam logic [31:0] AN = {`CWB_OFF_COUNT, 2'h0};
  localparam logic [31:0] AA = {`CWB_OFF_ADDR, 2'h0};
  localparam logic [31:0] AS = {`CWB_OFF_STAT, 2'h0};
  logic clk_sys_i = 1'b0, resetn_i = 1'b0, hsel = 1'b0, hwr = 1'b0;
  logic [1:0] htr = 2'h0;
  logic [31:0] haddr = 32'h0, hwd = 32'h0, fw = 32'h0, hrd, rd_s, rd, fetch, sw;
  logic svc = 1'b0, so = 1'b0, tag = 1'b0, sts = 1'b0, chn = 1'b0;
  logic hrdy, hresp, rdy, req, done, chk;
  logic [8:0] byt = 9'h0, ob;
  logic [15:0] cnt;
  logic [3:0] flg, slow = 4'h0;
  int error_cnt = 0, n_checks = 0, cyc = 0, w;

  cwb_buffer i_dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htr), .hwrite_i(hwr), .hsize_i(3'h2), .hwdata_i(hwd), .hready_i(hrdy),
    .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrd), .ch_byte_i(byt),
    .ch_svc_i(svc), .ch_ready_o(rdy), .ch_svc_out_i(so), .ch_inbound_tag_i(tag),
    .ch_status_in_i(sts), .ch_chain_data_i(chn), .ch_out_byte_o(ob),
    .st_fetch_word_i(fetch), .st_count_i(cnt), .st_share_done_i(done),
    .st_share_req_o(req), .st_store_word_o(sw), .st_mem_flag_o(flg), .check_o(chk));
  cwb_store_model i_mem (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .req_i(req), .slow_i(slow),
    .word_i(fw), .cnt_i(16'h0100), .done_o(done), .fetch_o(fetch), .count_o(cnt));

  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) rd_s <= hrd;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc > 5000) begin
      error_cnt++;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    htr <= 2'h2;
    haddr <= a;
    hwr <= wr;
    do @(posedge clk_sys_i); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htr <= 2'h0;
    hwd <= d;
    do @(posedge clk_sys_i); while (hrdy !== 1'b1);
    #1 rd = rd_s;
  endtask : bus

  task automatic put(input logic [7:0] d);
    #1;
    `WAIT(rdy === 1'b1)
    @(posedge clk_sys_i);
    byt <= {~^d, d};
    svc <= 1'b1;
    @(posedge clk_sys_i);
    svc <= 1'b0;
    byt <= {^d, ~d};
  endtask : put

  task automatic sout;
    @(posedge clk_sys_i);
    so <= 1'b1;
    @(posedge clk_sys_i);
    so <= 1'b0;
  endtask : sout

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    bus(0, AS, 32'h0);
    `CHK(rd[7:0], 8'h00)
    bus(0, 32'h10, 32'h0);
    `CHK({hresp, rd}, 33'h0)
    bus(1, AN, 32'h0100);
    bus(1, AA, 32'h0);
    bus(1, AC, 32'h1);
    for (int i = 1; i < 5; i++) put(8'(i * 17));
    repeat (8) @(posedge clk_sys_i);
    #1 `CHK(req, 1'b0)
    bus(0, AS, 32'h0);
    `CHK(rd[3:0], 4'hF)
    `CHK(rd[12:8], 5'h04)
    bus(1, AC, 32'h9);
    `WAIT(done === 1'b1)
    `CHK(sw, 32'h44332211)
    `CHK(flg, 4'hF)
    bus(0, AS, 32'h0);
    `CHK(rd[3:0], 4'h0)
    bus(1, AA, 32'h1);
    bus(1, AC, 32'h19);
    bus(0, AS, 32'h0);
    `CHK(rd[3:0], 4'h1)
    for (int i = 1; i < 4; i++) put(8'hA0 + 8'(i));
    `WAIT(done === 1'b1)
    `CHK(sw[31:8], 24'hA3A2A1)
    `CHK(flg, 4'hE)
    bus(1, AA, 32'h3);
    bus(1, AC, 32'hB);
    for (int i = 1; i < 5; i++) put(8'hB0 + 8'(i));
    `WAIT(done === 1'b1)
    `CHK(sw, 32'hB1B2B3B4)
    bus(1, AA, 32'h0);
    bus(1, AC, 32'h9);
    slow <= 4'h3;
    put(8'hC1);
    repeat (6) @(posedge clk_sys_i);
    #1 `CHK(req, 1'b0)
    @(posedge clk_sys_i);
    sts <= 1'b1;
    `WAIT(done === 1'b1)
    `CHK(sw[7:0], 8'hC1)
    @(posedge clk_sys_i);
    sts <= 1'b0;
    slow <= 4'h0;
    fw <= 32'h87654321;
    bus(1, AC, 32'h8);
    `WAIT(req === 1'b1)
    `CHK({req, rdy}, 2'b10)
    `WAIT(ob[7:0] === 8'h21)
    `CHK(ob[7:0], 8'h21)
    for (int j = 1; j < 4; j++) begin
      if (j == 1) begin
        @(posedge clk_sys_i);
        tag <= 1'b1;
      end
      sout();
      if (j == 1) begin
        repeat (6) @(posedge clk_sys_i);
        #1 `CHK(ob[7:0], 8'h21)
        @(posedge clk_sys_i);
        tag <= 1'b0;
      end
      `WAIT(ob[7:0] === fw[8 * j +: 8])
      `CHK(ob[7:0], fw[8 * j +: 8])
    end
    bus(1, AC, 32'hC);
    sout();
    repeat (6) @(posedge clk_sys_i);
    #1 `CHK(ob[7:0], 8'h87)
    bus(1, AC, 32'h8);
    `WAIT(ob[7:0] === 8'h21)
    `CHK(ob[7:0], 8'h21)
    @(posedge clk_sys_i);
    chn <= 1'b1;
    @(posedge clk_sys_i);
    chn <= 1'b0;
    bus(0, AS, 32'h0);
    `CHK(rd[15], 1'b1)
    bus(1, AA, 32'h0);
    bus(0, AS, 32'h0);
    `CHK(rd[13], 1'b0)
    `CHK(rd[15], 1'b0)
    conclude();
  end
endmodule : tb
